// *** rtl/dhdg_params.svh ***
`ifndef DHDG_PARAMS_SVH
`define DHDG_PARAMS_SVH
// ----------------------------------------------------------------
// Address map (byte addresses, upper nibble decodes)
// ----------------------------------------------------------------
`define DHDG_REGION_MSB 31
`define DHDG_REGION_LSB 28
`define DHDG_DRAM_HI_A 4'h2
`define DHDG_DRAM_HI_B 4'h3
`define DHDG_CFG_HI 4'h1
`define DHDG_PERIPH_HI 4'h0
// Slave decode: address bits 27:25 pick the peripheral
`define DHDG_SLV_MSB 27
`define DHDG_SLV_LSB 25
`define DHDG_SLV_EPROM 3'h0
`define DHDG_SLV_LATCH 3'h1
`define DHDG_SLV_SWITCH 3'h2
`define DHDG_SLV_UART 3'h3
`define DHDG_SLV_RTC 3'h4
// ----------------------------------------------------------------
// Transfer size encodings
// ----------------------------------------------------------------
`define DHDG_SIZ_LONG 2'h0
`define DHDG_SIZ_BYTE 2'h1
`define DHDG_SIZ_WORD 2'h2
`define DHDG_SIZ_LINE 2'h3
// Transfer-type code for interrupt acknowledge
`define DHDG_TT_INTERRUPT_ACK_SELECT 2'h3
// Acks in a line burst
`define DHDG_BURST_ACKS 3'h4
// Slow strobe delay in clocks after the primary control
`define DHDG_SLOW_DELAY 2'h1
`endif

// *** rtl/dhdg_pkg.sv ***
package dhdg_pkg;
  typedef enum logic [1:0] {
    DHDG_SEL_NONE = 2'b00,
    DHDG_SEL_DRAM = 2'b01,
    DHDG_SEL_PERIPH = 2'b10,
    DHDG_SEL_INTERRUPT_ACK_SELECT = 2'b11
  } dhdg_sel_t;
  typedef enum logic [1:0] {
    DHDG_ST_IDLE = 2'b00,
    DHDG_ST_START = 2'b01,
    DHDG_ST_HOLD = 2'b10
  } dhdg_state_t;
  // Module sizes selectable for address mapping
  typedef enum logic [1:0] {
    DHDG_MOD_1M = 2'b00,
    DHDG_MOD_2M = 2'b01,
    DHDG_MOD_4M = 2'b10,
    DHDG_MOD_8M = 2'b11
  } dhdg_modsize_t;
endpackage : dhdg_pkg

// *** rtl/dhdg_lane_enable.sv ***
`timescale 1ns/1ps
`include "dhdg_params.svh"
module dhdg_lane_enable (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Transfer attributes
  input wire logic [1:0] addr_low,
  input wire logic [1:0] transfer_size,
  input wire logic load,
  // Lane enables, registered, active high
  output logic [3:0] lane_en_reg
);
  import dhdg_pkg::*;
  typedef struct packed {
    logic [3:0] lanes;
  } dhdg_lane_state_t;
  dhdg_lane_state_t st_reg;
  dhdg_lane_state_t st_next;
  logic [3:0] decoded;
  always_comb begin
    st_next = st_reg;
    decoded = 4'h0;
    // Lane 3 is the most significant byte (big-endian bus)
    case (transfer_size)
      `DHDG_SIZ_BYTE: decoded = 4'h8 >> addr_low;
      `DHDG_SIZ_WORD: decoded = addr_low[1] ? 4'h3 : 4'hc;
      default: decoded = 4'hf;
    endcase
    if (load) begin
      st_next.lanes = decoded;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign lane_en_reg = st_reg.lanes;
endmodule : dhdg_lane_enable

// *** rtl/dhdg_addr_map.sv ***
`timescale 1ns/1ps
module dhdg_addr_map (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Inputs
  input wire logic [27:0] addr_in,
  input wire dhdg_pkg::dhdg_modsize_t mod_size,
  input wire logic cfg_cycle,
  input wire logic load,
  // Controller address inputs, registered
  output logic [11:0] row_col_reg,
  output logic bank_reg
);
  import dhdg_pkg::*;
  typedef struct packed {
    logic [11:0] rc;
    logic bank;
  } dhdg_map_state_t;
  dhdg_map_state_t st_reg;
  dhdg_map_state_t st_next;
  always_comb begin
    st_next = st_reg;
    if (load) begin
      if (cfg_cycle) begin
        // Mode bits ride straight on the low address lines
        st_next.rc = addr_in[13:2];
        st_next.bank = addr_in[14];
      end else begin
        // Bank bit sits just above the module's span
        st_next.rc = addr_in[13:2];
        case (mod_size)
          DHDG_MOD_1M: st_next.bank = addr_in[22];
          DHDG_MOD_2M: st_next.bank = addr_in[23];
          DHDG_MOD_4M: st_next.bank = addr_in[24];
          default: st_next.bank = addr_in[25];
        endcase
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign row_col_reg = st_reg.rc;
  assign bank_reg = st_reg.bank;
endmodule : dhdg_addr_map

// *** rtl/dhdg_glue.sv ***
`timescale 1ns/1ps
`include "dhdg_params.svh"
module dhdg_glue #(
  parameter bit INVERT_CTRL_CLK = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Processor bus, already on sys_clk
  input wire logic [31:0] cpu_addr,
  input wire logic [1:0] transfer_size,
  input wire logic [1:0] transfer_type,
  input wire logic cpu_rd_n_wr,
  input wire logic transfer_start_strobe_n,
  // Module size selection
  input wire dhdg_pkg::dhdg_modsize_t mod_size,
  // Wait-state machine and controller handshakes
  input wire logic wait_first_state,
  input wire logic ctrl_ack_n,
  // Master decode outputs
  output logic dram_select_reg,
  output logic interrupt_ack_select_reg,
  output logic periph_select_reg,
  output logic cache_inhibit_reg,
  // Slave decode outputs
  output logic [4:0] dev_select_reg,
  output logic config_load_strobe_n_reg,
  output logic slow_rd_reg,
  output logic slow_wr_reg,
  // Controller side
  output logic access_start_strobe_n_reg,
  output logic burst_req_reg,
  output logic [3:0] lane_column_strobe_reg,
  output logic [11:0] ctrl_row_col_reg,
  output logic ctrl_bank_reg,
  output logic transfer_ack_out_n_reg,
  output logic mode_loaded_reg,
  output logic ctrl_clk_invert_reg
);
  import dhdg_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    dhdg_state_t state;
    dhdg_sel_t sel;
    logic burst;
    logic [2:0] ack_cnt;
    logic cinh;
    logic [4:0] dev;
    logic cfg_n;
    logic ads_n;
    logic ta_n;
    logic loaded;
    logic [1:0] slow_cnt;
    logic srd;
    logic swr;
    logic is_write;
    // Registered output copies
    logic dsel;
    logic isel;
    logic psel;
    logic breq;
    logic cinv;
  } dhdg_glue_state_t;

  dhdg_glue_state_t st_reg;
  dhdg_glue_state_t st_next;

  logic [3:0] region;
  logic [2:0] slv_field;
  logic ts_seen;
  logic hit_dram;
  logic hit_cfg;
  logic hit_interrupt_ack_select;
  logic lane_load;
  logic map_load;

  assign region = cpu_addr[`DHDG_REGION_MSB:`DHDG_REGION_LSB];
  assign slv_field = cpu_addr[`DHDG_SLV_MSB:`DHDG_SLV_LSB];
  // Start is sampled on the clock edge only; glitches between edges never open a decode
  assign ts_seen = !transfer_start_strobe_n && st_reg.state == DHDG_ST_IDLE;
  assign hit_interrupt_ack_select = transfer_type == `DHDG_TT_INTERRUPT_ACK_SELECT;
  assign hit_dram = !hit_interrupt_ack_select && (region == `DHDG_DRAM_HI_A || region == `DHDG_DRAM_HI_B);
  assign hit_cfg = !hit_interrupt_ack_select && region == `DHDG_CFG_HI && !cpu_rd_n_wr;
  assign lane_load = ts_seen;
  assign map_load = ts_seen && (hit_dram || hit_cfg);

  // ----------------------------------------------------------------
  // Decode and cycle tracking
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.cfg_n = 1'b1;
    st_next.ta_n = 1'b1;
    st_next.srd = 1'b0;
    st_next.swr = 1'b0;
    case (st_reg.state)
      DHDG_ST_IDLE: begin
        st_next.ads_n = 1'b1;
        if (ts_seen) begin
          st_next.state = DHDG_ST_START;
          st_next.is_write = !cpu_rd_n_wr;
          st_next.ack_cnt = 3'h0;
          st_next.burst = 1'b0;
          st_next.dev = 5'h00;
          st_next.slow_cnt = 2'h0;
          st_next.cinh = 1'b1;
          if (hit_interrupt_ack_select) begin
            st_next.sel = DHDG_SEL_INTERRUPT_ACK_SELECT;
          end else if (hit_dram && st_reg.loaded) begin
            // Memory stays unusable until the mode is loaded; such cycles go nowhere
            st_next.sel = DHDG_SEL_DRAM;
            st_next.cinh = 1'b0;
            st_next.burst = transfer_size == `DHDG_SIZ_LINE;
          end else if (hit_cfg) begin
            st_next.sel = DHDG_SEL_PERIPH;
          end else if (!hit_dram && region == `DHDG_PERIPH_HI) begin
            st_next.sel = DHDG_SEL_PERIPH;
          end else begin
            st_next.sel = DHDG_SEL_NONE;
          end
        end
      end
      DHDG_ST_START: begin
        st_next.state = DHDG_ST_HOLD;
        if (st_reg.sel == DHDG_SEL_DRAM) begin
          st_next.ads_n = 1'b0;
        end else if (st_reg.sel == DHDG_SEL_PERIPH && region == `DHDG_CFG_HI) begin
          st_next.cfg_n = 1'b0;
          st_next.loaded = 1'b1;
          st_next.ta_n = 1'b0;
          st_next.sel = DHDG_SEL_NONE;
          st_next.state = DHDG_ST_IDLE;
        end
      end
      DHDG_ST_HOLD: begin
        if (st_reg.sel == DHDG_SEL_DRAM) begin
          st_next.ads_n = 1'b1;
          if (!ctrl_ack_n) begin
            st_next.ta_n = 1'b0;
            st_next.ack_cnt = st_reg.ack_cnt + 3'h1;
            // Drop the burst request once three beats are in, ahead of the last ack
            if (st_reg.ack_cnt + 3'h2 >= `DHDG_BURST_ACKS) begin
              st_next.burst = 1'b0;
            end
            if (!st_reg.burst || st_reg.ack_cnt + 3'h1 >= `DHDG_BURST_ACKS) begin
              st_next.sel = DHDG_SEL_NONE;
              st_next.state = DHDG_ST_IDLE;
            end
          end
        end else if (st_reg.sel == DHDG_SEL_PERIPH) begin
          // Slow devices open only from the wait machine's first state onward
          if (wait_first_state) begin
            case (slv_field)
              `DHDG_SLV_EPROM: st_next.dev = 5'h01;
              `DHDG_SLV_LATCH: st_next.dev = 5'h02;
              `DHDG_SLV_SWITCH: st_next.dev = 5'h04;
              `DHDG_SLV_UART: st_next.dev = 5'h08;
              `DHDG_SLV_RTC: st_next.dev = 5'h10;
              default: st_next.dev = 5'h00;
            endcase
          end
          if (st_reg.dev != 5'h00) begin
            if (st_reg.slow_cnt >= `DHDG_SLOW_DELAY) begin
              st_next.srd = !st_reg.is_write;
              st_next.swr = st_reg.is_write;
            end else begin
              st_next.slow_cnt = st_reg.slow_cnt + 2'h1;
            end
          end
          // Peripheral cycle ends when the wait machine's external ack lands
          if (!ctrl_ack_n) begin
            st_next.sel = DHDG_SEL_NONE;
            st_next.dev = 5'h00;
            st_next.state = DHDG_ST_IDLE;
          end
        end else begin
          if (!ctrl_ack_n) begin
            st_next.sel = DHDG_SEL_NONE;
            st_next.state = DHDG_ST_IDLE;
          end
        end
      end
      default: begin
        st_next.state = DHDG_ST_IDLE;
        st_next.sel = DHDG_SEL_NONE;
      end
    endcase
    // Decode flags are registered copies, so every select leaves straight from a flop
    // and no compare glitch reaches the memory or peripheral side
    // They follow the next selection, so they show up on the same edge as the select
    st_next.dsel = st_next.sel == DHDG_SEL_DRAM;
    st_next.isel = st_next.sel == DHDG_SEL_INTERRUPT_ACK_SELECT;
    st_next.psel = st_next.sel == DHDG_SEL_PERIPH;
    st_next.breq = st_next.burst && st_next.sel == DHDG_SEL_DRAM;
    st_next.cinv = INVERT_CTRL_CLK;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg.state <= DHDG_ST_IDLE;
      st_reg.sel <= DHDG_SEL_NONE;
      st_reg.burst <= 1'b0;
      st_reg.ack_cnt <= 3'h0;
      st_reg.cinh <= 1'b1;
      st_reg.dev <= 5'h00;
      st_reg.cfg_n <= 1'b1;
      st_reg.ads_n <= 1'b1;
      st_reg.ta_n <= 1'b1;
      st_reg.loaded <= 1'b0;
      st_reg.slow_cnt <= 2'h0;
      st_reg.srd <= 1'b0;
      st_reg.swr <= 1'b0;
      st_reg.is_write <= 1'b0;
      st_reg.dsel <= 1'b0;
      st_reg.isel <= 1'b0;
      st_reg.psel <= 1'b0;
      st_reg.breq <= 1'b0;
      // The build option survives reset so the clock wiring outside never sees a glitch
      st_reg.cinv <= INVERT_CTRL_CLK;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The burst drop looks two beats ahead, so fewer than two acks per line cannot be served
  if (`DHDG_BURST_ACKS < 3'h2) begin : g_bad_burst_acks
    $error("burst ack count below two");
  end
  // A zero delay would let the slow strobes rise only one clock after the device select
  if (`DHDG_SLOW_DELAY == 2'h0) begin : g_bad_slow_delay
    $error("slow strobe delay must be at least one clock");
  end

  // ----------------------------------------------------------------
  // Lane enables and controller address mapping
  // ----------------------------------------------------------------
  logic [3:0] lane_en;

  dhdg_lane_enable u_lane (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .addr_low(cpu_addr[1:0]),
    .transfer_size(transfer_size),
    .load(lane_load),
    .lane_en_reg(lane_en)
  );

  dhdg_addr_map u_map (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .addr_in(cpu_addr[27:0]),
    .mod_size(mod_size),
    .cfg_cycle(hit_cfg),
    .load(map_load),
    .row_col_reg(ctrl_row_col_reg),
    .bank_reg(ctrl_bank_reg)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dram_select_reg = st_reg.dsel;
  assign interrupt_ack_select_reg = st_reg.isel;
  assign periph_select_reg = st_reg.psel;
  assign cache_inhibit_reg = st_reg.cinh;
  // Only lane 3 matters on peripheral cycles; others are don't-care to readers
  assign dev_select_reg = st_reg.dev;
  assign config_load_strobe_n_reg = st_reg.cfg_n;
  assign slow_rd_reg = st_reg.srd;
  assign slow_wr_reg = st_reg.swr;
  assign access_start_strobe_n_reg = st_reg.ads_n;
  assign burst_req_reg = st_reg.breq;
  // Lane and address outputs leave the submodules' own registers
  assign lane_column_strobe_reg = lane_en;
  assign transfer_ack_out_n_reg = st_reg.ta_n;
  assign mode_loaded_reg = st_reg.loaded;
  // Build option flag; wait logic and clock wiring outside follow it
  assign ctrl_clk_invert_reg = st_reg.cinv;
endmodule : dhdg_glue

// *** verification/dhdg_glue_chk.sv ***
`timescale 1ns/1ps
module dhdg_glue_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Bus side
  input wire logic [31:0] cpu_addr,
  input wire logic cpu_rd_n_wr,
  input wire logic transfer_start_strobe_n,
  input wire logic wait_first_state,
  input wire logic ctrl_ack_n,
  // Decode outputs
  input wire logic dram_select_reg,
  input wire logic interrupt_ack_select_reg,
  input wire logic periph_select_reg,
  input wire logic cache_inhibit_reg,
  input wire logic [4:0] dev_select_reg,
  input wire logic config_load_strobe_n_reg,
  input wire logic slow_rd_reg,
  input wire logic access_start_strobe_n_reg,
  input wire logic burst_req_reg,
  input wire logic transfer_ack_out_n_reg,
  input wire logic mode_loaded_reg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  chk_ads_after_sel: assert property ($rose(dram_select_reg) |=> !access_start_strobe_n_reg)
    else $error("memory start strobe late");
  chk_sel_on_start: assert property ($rose(dram_select_reg) |-> !$past(transfer_start_strobe_n))
    else $error("memory select without start");
  chk_sel_exclusive: assert property (!(dram_select_reg && periph_select_reg)
    && !(interrupt_ack_select_reg && (dram_select_reg || periph_select_reg))) else $error("selects overlap");
  chk_cinh_other: assert property ((periph_select_reg || interrupt_ack_select_reg) |-> cache_inhibit_reg)
    else $error("cache inhibit missing");
  chk_single_release: assert property (dram_select_reg && !burst_req_reg && !ctrl_ack_n
    |=> !dram_select_reg && !transfer_ack_out_n_reg) else $error("single cycle not released");
  chk_burst_hold: assert property (dram_select_reg && burst_req_reg && !ctrl_ack_n
    |=> dram_select_reg && !transfer_ack_out_n_reg) else $error("burst select dropped");
  chk_load_on_write: assert property (!config_load_strobe_n_reg |-> $past(periph_select_reg)
    && !cpu_rd_n_wr && cpu_addr[31:28] == 4'h1) else $error("load strobe without hole write");
  chk_mode_gate: assert property (!access_start_strobe_n_reg |-> mode_loaded_reg)
    else $error("memory start before mode load");
  chk_dev_gated: assert property ($rose(|dev_select_reg) |-> $past(wait_first_state))
    else $error("device select not gated");
  chk_slow_after: assert property (slow_rd_reg |-> $past(|dev_select_reg) && cpu_rd_n_wr)
    else $error("slow read early");
  cov_burst: cover property (burst_req_reg && !ctrl_ack_n);
  cov_load: cover property (!config_load_strobe_n_reg);
  cov_slow: cover property (slow_rd_reg);
  cov_interrupt_ack_select: cover property (interrupt_ack_select_reg);
endmodule : dhdg_glue_chk

// *** verification/dhdg_ctrl_model.sv ***
`timescale 1ns/1ps
module dhdg_ctrl_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Observed cycle
  input wire logic transfer_start_strobe_n,
  input wire logic transfer_ack_out_n_reg,
  input wire logic periph_select_reg,
  // Answer shape
  input wire logic [3:0] lat,
  input wire logic [2:0] nacks,
  // Answers
  output logic ctrl_ack_n,
  output logic wait_first_state
);
  logic [3:0] cnt;
  logic [2:0] left;
  logic prev_ack;
  // A self-acked cycle (mode load) cancels the pending answer, or it would hit the next cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 4'h0;
      left <= 3'h0;
      prev_ack <= 1'b0;
      ctrl_ack_n <= 1'b1;
      wait_first_state <= 1'b0;
    end else begin
      prev_ack <= !ctrl_ack_n;
      wait_first_state <= periph_select_reg;
      ctrl_ack_n <= 1'b1;
      if (!transfer_start_strobe_n) begin
        cnt <= lat;
        left <= nacks;
      end else if (!transfer_ack_out_n_reg && !prev_ack) begin
        left <= 3'h0;
      end else if (left != 3'h0) begin
        if (cnt == 4'h0) begin
          ctrl_ack_n <= 1'b0;
          left <= left - 3'h1;
          cnt <= lat;
        end else begin
          cnt <= cnt - 4'h1;
        end
      end
    end
  end
endmodule : dhdg_ctrl_model

// *** verification/test_dram_host_decode_glue.sv ***
`timescale 1ns/1ps
module test_dram_host_decode_glue;
  import dhdg_pkg::*;
  logic sys_clk, rstn, rdw, ts_n, ack_n, wfs, mode_exp;
  logic dsel, isel, psel, cinh, cfg_n, srd, swr, ads_n, breq, bank, ta_n, mload, cinv;
  logic [31:0] addr, r1, r2;
  logic [1:0] size, ttype;
  logic [4:0] dev;
  logic [3:0] lanes, lat;
  logic [11:0] rc;
  logic [2:0] nacks;
  dhdg_modsize_t mods;
  int failures, num_checks, seed, i;
  dhdg_glue #(.INVERT_CTRL_CLK(1'b1)) dhdg_glue_i (
    .sys_clk(sys_clk), .rstn(rstn), .cpu_addr(addr), .transfer_size(size), .transfer_type(ttype),
    .cpu_rd_n_wr(rdw), .transfer_start_strobe_n(ts_n), .mod_size(mods), .wait_first_state(wfs),
    .ctrl_ack_n(ack_n), .dram_select_reg(dsel), .interrupt_ack_select_reg(isel), .periph_select_reg(psel),
    .cache_inhibit_reg(cinh), .dev_select_reg(dev), .config_load_strobe_n_reg(cfg_n), .slow_rd_reg(srd),
    .slow_wr_reg(swr), .access_start_strobe_n_reg(ads_n), .burst_req_reg(breq),
    .lane_column_strobe_reg(lanes), .ctrl_row_col_reg(rc), .ctrl_bank_reg(bank),
    .transfer_ack_out_n_reg(ta_n), .mode_loaded_reg(mload), .ctrl_clk_invert_reg(cinv));
  dhdg_ctrl_model dhdg_ctrl_model_i (
    .sys_clk(sys_clk), .rstn(rstn), .transfer_start_strobe_n(ts_n), .transfer_ack_out_n_reg(ta_n),
    .periph_select_reg(psel), .lat(lat), .nacks(nacks), .ctrl_ack_n(ack_n), .wait_first_state(wfs));
  // ----
  // Helpers
  // ----
  task automatic final_report;
    if (failures == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  function automatic logic [3:0] exp_lanes(input logic [1:0] a, input logic [1:0] s);
    case (s)
      2'h1: exp_lanes = 4'h8 >> a;
      2'h2: exp_lanes = a[1] ? 4'h3 : 4'hc;
      default: exp_lanes = 4'hf;
    endcase
  endfunction : exp_lanes
  // One cycle at a time; the address is held until the cycle is over
  task automatic bus_cycle(input logic [31:0] a, input logic [1:0] s, t, input logic r,
                           input logic [3:0] l, input logic [2:0] n);
    logic ia, dr, pr, cf, sr, sw;
    logic [4:0] dv;
    int k, tas, acks, tgt, ackt;
    ia = (t == 2'h3);
    dr = !ia && a[31:29] == 3'h1 && mode_exp;
    cf = !ia && a[31:28] == 4'h1 && !r;
    pr = !ia && a[31:29] == 3'h0;
    // Only memory cycles and the self-acked mode load return an acknowledge from this block
    tgt = cf ? 1 : (dr ? n : 0);
    ackt = cf ? 0 : n;
    @(negedge sys_clk);
    addr = a;
    size = s;
    ttype = t;
    rdw = r;
    lat = l;
    nacks = n;
    ts_n = 1'b0;
    @(negedge sys_clk);
    ts_n = 1'b1;
    chk(dsel, dr);
    chk(psel, pr);
    chk(isel, ia);
    if (dr || pr || ia) chk(cinh, !dr);
    if (dr) chk(lanes, exp_lanes(a[1:0], s));
    if (dr) chk(breq, s == 2'h3);
    if (dr) chk(bank, a[22 + mods]);
    if (cf) chk(rc, a[13:2]);
    @(negedge sys_clk);
    chk(ads_n, !dr);
    chk(cfg_n, !cf);
    if (cf) chk(mload, 1'b1);
    tas = 0;
    acks = 0;
    dv = 5'h00;
    sr = 1'b0;
    sw = 1'b0;
    for (k = 0; k < 60 && (tas < tgt || acks < ackt); k++) begin
      if (!ta_n) tas++;
      if (!ack_n) acks++;
      if (dr && !ack_n && acks == 4) chk(breq, 1'b0);
      if (dev !== 5'h00) dv = dev;
      sr = sr | srd;
      sw = sw | swr;
      @(negedge sys_clk);
    end
    chk(tas, tgt);
    chk({dsel, psel, isel}, 3'h0);
    if (pr && !cf) chk(dv, 5'h01 << a[27:25]);
    if (pr && !cf) chk({sr, sw}, {r, !r});
    repeat (2) @(negedge sys_clk);
  endtask : bus_cycle
  // ----
  // Stimulus
  // ----
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    #400000;
    failures++;
    final_report();
  end
  initial begin
    seed = 32'h5d25;
    {rstn, ts_n, rdw, mode_exp} = 4'h6;
    addr = 32'h0000_0000;
    {size, ttype} = 4'h0;
    mods = DHDG_MOD_1M;
    lat = 4'h2;
    nacks = 3'h1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rstn = 1'b1;
    chk({dsel, psel, isel, lanes, mload}, 8'h00);
    chk({cinh, cfg_n, ads_n, ta_n}, 4'hf);
    chk(cinv, 1'b1);
    bus_cycle(32'h2000_0010, 2'h0, 2'h0, 1'b1, 4'h2, 3'h1);
    r1 = $random(seed);
    bus_cycle({4'h1, r1[27:0]}, 2'h0, 2'h0, 1'b0, 4'h2, 3'h1);
    mode_exp = 1'b1;
    bus_cycle(32'h2000_0000, 2'h0, 2'h3, 1'b1, 4'h2, 3'h1);
    for (i = 0; i < 48; i++) begin
      r1 = $random(seed);
      r2 = $random(seed);
      mods = dhdg_modsize_t'(r2[3:2]);
      if (r2[7]) bus_cycle({3'h1, r1[28:0]}, r2[1:0], 2'h0, r2[6], 4'h2 + r2[5:4],
                           (r2[1:0] == 2'h3) ? 3'h4 : 3'h1);
      else bus_cycle({4'h0, 3'(r2[10:8] % 3'h5), r1[24:0]}, 2'h1, 2'h0, r2[6], 4'h6 + r2[5:4],
                     3'h1);
    end
    final_report();
  end
endmodule : test_dram_host_decode_glue
bind dhdg_glue dhdg_glue_chk dhdg_glue_chk_i (
  .sys_clk, .rstn, .cpu_addr, .cpu_rd_n_wr, .transfer_start_strobe_n, .wait_first_state, .ctrl_ack_n,
  .dram_select_reg, .interrupt_ack_select_reg, .periph_select_reg, .cache_inhibit_reg, .dev_select_reg,
  .config_load_strobe_n_reg, .slow_rd_reg, .access_start_strobe_n_reg, .burst_req_reg,
  .transfer_ack_out_n_reg, .mode_loaded_reg);
